/* File: ee_model.sv */
`timescale 1ns/1ps
module ee_model (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire eeprom_loader_pkg::ee_read_t rd_i,
    input wire logic slow_i,
    output logic done_o,
    output logic [7:0] data_o
);
    logic [7:0] mem [0:2047];
    logic [7:0] last;
    int wait_n;
    // one read in flight; byte handed over only when the latency runs out
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            done_o <= 1'b0;
            data_o <= 8'h00;
            last <= 8'h00;
            wait_n <= 0;
        end else begin
            done_o <= 1'b0;
            // released data line never repeats the last byte
            data_o <= ~last;
            if (rd_i.req) begin
                wait_n <= slow_i ? 6 : 1;
            end else if (wait_n == 1) begin
                done_o <= 1'b1;
                data_o <= mem[rd_i.addr[10:0]];
                last <= mem[rd_i.addr[10:0]];
                wait_n <= 0;
            end else if (wait_n > 1) begin
                wait_n <= wait_n - 1;
            end
        end
    end
endmodule : ee_model

/* File: eeprom_config_loader.sv */
`timescale 1ns/1ps
module eeprom_config_loader (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [7:0] bus_addr_i,
    input wire logic [31:0] bus_wdata_i,
    input wire logic bus_wr_i,
    input wire logic bus_rd_i,
    output logic [31:0] bus_rdata_o,
    input wire logic [31:0] strap_pins_i,
    input wire logic [1:0] eeprom_size_strap_i,
    output eeprom_loader_pkg::ee_read_t ee_rd_o,
    input wire logic ee_done_i,
    input wire logic [7:0] ee_data_i,
    input wire logic csr_busy_i,
    input wire logic pmi_busy_i,
    output eeprom_loader_pkg::reg_write_t reg_wr_o,
    output eeprom_loader_pkg::sync_write_t sync_wr_o,
    output logic [31:0] mac_addr_low_o,
    output logic [15:0] mac_addr_high_o,
    output logic [31:0] strap_o,
    output logic loader_busy_o,
    output logic ready_o,
    output logic addr_overflow_o
);

    function automatic logic [11:0] size_limit(input logic [1:0] sel);
        case (sel)
            eeprom_loader_pkg::SIZE_7BIT: size_limit = eeprom_loader_pkg::LIMIT_7BIT;
            eeprom_loader_pkg::SIZE_9BIT: size_limit = eeprom_loader_pkg::LIMIT_9BIT;
            // reserved code treated as the widest range
            default: size_limit = eeprom_loader_pkg::LIMIT_11BIT;
        endcase
    endfunction : size_limit

    eeprom_loader_pkg::loader_state_t state;
    logic start_pend;
    logic sampled;
    logic [1:0] size_sel;
    logic [11:0] ee_addr;
    logic [7:0] cur_byte;
    logic strap_ok;
    logic end_after_sync;
    logic in_sync;
    logic [3:0] sync_idx;
    logic [7:0] bursts_left;
    logic [7:0] dw_left;
    logic [7:0] dw_addr;
    logic [2:0] byte_pos;
    logic [31:0] dword;
    logic over_limit;
    logic trigger;
    logic dispatching;

    assign over_limit = ee_addr > size_limit(size_sel);
    assign dispatching = state == eeprom_loader_pkg::S_DISPATCH;
    assign trigger = bus_wr_i && ((bus_addr_i == eeprom_loader_pkg::REG_CMD
                     && bus_wdata_i[eeprom_loader_pkg::CMD_RELOAD_BIT])
                     || (bus_addr_i == eeprom_loader_pkg::REG_RESET_CONTROL_REG
                     && bus_wdata_i[eeprom_loader_pkg::RESET_DIGITAL_BIT]));

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // pending start; set after reset and wins over the take
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            start_pend <= 1'b1;
        end else if (trigger) begin
            start_pend <= 1'b1;
        end else if (state == eeprom_loader_pkg::S_IDLE) begin
            start_pend <= 1'b0;
        end
    end

    // straps caught on the first edge after release, never under reset
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sampled <= 1'b0;
            size_sel <= 2'h0;
            strap_o <= 32'h0000_0000;
        end else if (!sampled) begin
            sampled <= 1'b1;
            size_sel <= eeprom_size_strap_i;
            strap_o <= strap_pins_i;
        end else if (dispatching && strap_ok && ee_addr >= eeprom_loader_pkg::ADDR_STRAP_FIRST
                     && ee_addr <= eeprom_loader_pkg::ADDR_STRAP_LAST) begin
            strap_o[{ee_addr[1:0], 3'h0} +: 8] <= cur_byte;
        end
    end

    a_strap_skip: assert property (dispatching && !strap_ok
        && ee_addr[11:2] == 10'h002 |=> $stable(strap_o)) else $error("discarded byte kept");

    // mac address bytes
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mac_addr_low_o <= 32'h0000_0000;
            mac_addr_high_o <= 16'h0000;
        end else if (dispatching && ee_addr != eeprom_loader_pkg::ADDR_VALID) begin
            if (ee_addr <= eeprom_loader_pkg::ADDR_MAC_LO_3) begin
                mac_addr_low_o[{ee_addr[1:0] - 2'h1, 3'h0} +: 8] <= cur_byte;
            end else if (ee_addr <= eeprom_loader_pkg::ADDR_MAC_HI_1) begin
                mac_addr_high_o[{ee_addr[0] ^ 1'b1, 3'h0} +: 8] <= cur_byte;
            end
        end
    end

    a_mac_top: assert property (dispatching
        && ee_addr == eeprom_loader_pkg::ADDR_MAC_LO_3
        |=> mac_addr_low_o[31:24] == $past(cur_byte)) else $error("mac low top byte wrong");

    // sequencer
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state <= eeprom_loader_pkg::S_IDLE;
            ee_addr <= 12'h000;
            cur_byte <= 8'h00;
            strap_ok <= 1'b0;
            end_after_sync <= 1'b0;
            in_sync <= 1'b0;
            sync_idx <= 4'h0;
            bursts_left <= 8'h00;
            dw_left <= 8'h00;
            dw_addr <= 8'h00;
            byte_pos <= 3'h0;
            dword <= 32'h0000_0000;
        end else begin
            case (state)
                eeprom_loader_pkg::S_IDLE: begin
                    if (start_pend) begin
                        state <= eeprom_loader_pkg::S_RD_REQ;
                        ee_addr <= eeprom_loader_pkg::ADDR_VALID;
                        strap_ok <= 1'b0;
                        end_after_sync <= 1'b0;
                        sync_idx <= 4'h0;
                        byte_pos <= eeprom_loader_pkg::POS_HDR_ADDR;
                    end
                end
                eeprom_loader_pkg::S_RD_REQ: begin
                    // no read is issued past the part
                    state <= over_limit ? eeprom_loader_pkg::S_IDLE
                                        : eeprom_loader_pkg::S_RD_WAIT;
                end
                eeprom_loader_pkg::S_RD_WAIT: begin
                    if (ee_done_i && !ee_rd_o.req) begin
                        cur_byte <= ee_data_i;
                        state <= eeprom_loader_pkg::S_DISPATCH;
                    end
                end
                eeprom_loader_pkg::S_DISPATCH: begin
                    state <= eeprom_loader_pkg::S_RD_REQ;
                    ee_addr <= ee_addr + 12'h001;
                    if (ee_addr == eeprom_loader_pkg::ADDR_VALID
                        && cur_byte != eeprom_loader_pkg::VALID_FLAG) begin
                        end_after_sync <= 1'b1;
                        in_sync <= 1'b1;
                        state <= eeprom_loader_pkg::S_WAIT_FREE;
                    end else if (ee_addr == eeprom_loader_pkg::ADDR_STRAP_FLAG) begin
                        strap_ok <= cur_byte == eeprom_loader_pkg::VALID_FLAG;
                    end else if (ee_addr == eeprom_loader_pkg::ADDR_STRAP_LAST) begin
                        in_sync <= 1'b1;
                        state <= eeprom_loader_pkg::S_WAIT_FREE;
                    end else if (ee_addr == eeprom_loader_pkg::ADDR_BURST_FLAG) begin
                        if (cur_byte != eeprom_loader_pkg::VALID_FLAG) begin
                            state <= eeprom_loader_pkg::S_IDLE;
                        end
                    end else if (ee_addr == eeprom_loader_pkg::ADDR_BURST_COUNT) begin
                        bursts_left <= cur_byte;
                        if (cur_byte == 8'h00) begin
                            state <= eeprom_loader_pkg::S_IDLE;
                        end
                    end else if (ee_addr > eeprom_loader_pkg::ADDR_BURST_COUNT) begin
                        case (byte_pos)
                            eeprom_loader_pkg::POS_HDR_ADDR: begin
                                dw_addr <= cur_byte;
                                byte_pos <= eeprom_loader_pkg::POS_HDR_COUNT;
                            end
                            eeprom_loader_pkg::POS_HDR_COUNT: begin
                                dw_left <= cur_byte;
                                byte_pos <= eeprom_loader_pkg::POS_DATA_FIRST;
                                // an empty burst moves straight on
                                if (cur_byte == 8'h00) begin
                                    byte_pos <= eeprom_loader_pkg::POS_HDR_ADDR;
                                    bursts_left <= bursts_left - 8'h01;
                                    if (bursts_left == 8'h01) begin
                                        state <= eeprom_loader_pkg::S_IDLE;
                                    end
                                end
                            end
                            default: begin
                                dword <= {dword[23:0], cur_byte};
                                byte_pos <= byte_pos + 3'h1;
                                if (byte_pos == eeprom_loader_pkg::POS_DATA_LAST) begin
                                    in_sync <= 1'b0;
                                    state <= eeprom_loader_pkg::S_WAIT_FREE;
                                end
                            end
                        endcase
                    end
                end
                eeprom_loader_pkg::S_WAIT_FREE: begin
                    if (!csr_busy_i && !pmi_busy_i) begin
                        state <= in_sync ? eeprom_loader_pkg::S_SYNC_WR
                                         : eeprom_loader_pkg::S_BURST_WR;
                    end
                end
                eeprom_loader_pkg::S_SYNC_WR: begin
                    sync_idx <= sync_idx + 4'h1;
                    state <= eeprom_loader_pkg::S_WAIT_FREE;
                    if (sync_idx == eeprom_loader_pkg::SYNC_LAST) begin
                        sync_idx <= 4'h0;
                        state <= end_after_sync ? eeprom_loader_pkg::S_IDLE
                                                : eeprom_loader_pkg::S_RD_REQ;
                    end
                end
                eeprom_loader_pkg::S_BURST_WR: begin
                    dw_addr <= dw_addr + 8'h01;
                    dw_left <= dw_left - 8'h01;
                    byte_pos <= eeprom_loader_pkg::POS_DATA_FIRST;
                    state <= eeprom_loader_pkg::S_RD_REQ;
                    if (dw_left == 8'h01) begin
                        byte_pos <= eeprom_loader_pkg::POS_HDR_ADDR;
                        bursts_left <= bursts_left - 8'h01;
                        if (bursts_left == 8'h01) begin
                            state <= eeprom_loader_pkg::S_IDLE;
                        end
                    end
                end
                default: begin
                    state <= eeprom_loader_pkg::S_IDLE;
                end
            endcase
        end
    end

    sequence s_request;
        state == eeprom_loader_pkg::S_RD_REQ && !over_limit;
    endsequence

    sequence s_pulse_then_wait;
        ee_rd_o.req && state == eeprom_loader_pkg::S_RD_WAIT ##1 !ee_rd_o.req;
    endsequence

    a_fetch_pulse: assert property (s_request |=> s_pulse_then_wait)
        else $error("read request not a single pulse");
    a_fetch_hold: assert property (state == eeprom_loader_pkg::S_RD_WAIT && !ee_done_i
        |=> state == eeprom_loader_pkg::S_RD_WAIT) else $error("byte used before read done");
    a_bad_valid: assert property (dispatching
        && ee_addr == eeprom_loader_pkg::ADDR_VALID && cur_byte != eeprom_loader_pkg::VALID_FLAG
        |=> end_after_sync && state == eeprom_loader_pkg::S_WAIT_FREE)
        else $error("invalid image not sent to resync and stop");

    // eeprom read port
    logic [11:0] last_rd_addr;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ee_rd_o <= '0;
            last_rd_addr <= 12'h000;
        end else begin
            ee_rd_o.req <= state == eeprom_loader_pkg::S_RD_REQ && !over_limit;
            ee_rd_o.addr <= ee_addr;
            if (ee_rd_o.req) begin
                last_rd_addr <= ee_rd_o.addr;
            end
        end
    end

    a_read_order: assert property (ee_rd_o.req
        && ee_rd_o.addr != eeprom_loader_pkg::ADDR_VALID
        |-> ee_rd_o.addr == last_rd_addr + 12'h001) else $error("eeprom reads not ascending");
    // register writes, burst and resync
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_wr_o <= '0;
            sync_wr_o <= '0;
        end else begin
            reg_wr_o.wr <= state == eeprom_loader_pkg::S_BURST_WR;
            reg_wr_o.addr <= {dw_addr, 2'h0};
            reg_wr_o.data <= dword;
            sync_wr_o.wr <= state == eeprom_loader_pkg::S_SYNC_WR;
            sync_wr_o.sel <= sync_idx;
            sync_wr_o.restart_an <= sync_idx == eeprom_loader_pkg::SYNC_PORT1_BASIC
                                 || sync_idx == eeprom_loader_pkg::SYNC_PORT2_BASIC
                                 || sync_idx == eeprom_loader_pkg::SYNC_VIRT_BASIC;
        end
    end

    a_write_free: assert property ((reg_wr_o.wr || sync_wr_o.wr)
        |-> $past(!csr_busy_i && !pmi_busy_i, 2)) else $error("write issued while busy");
    a_restart_an: assert property (sync_wr_o.wr
        && (sync_wr_o.sel == eeprom_loader_pkg::SYNC_PORT1_BASIC
        || sync_wr_o.sel == eeprom_loader_pkg::SYNC_PORT2_BASIC
        || sync_wr_o.sel == eeprom_loader_pkg::SYNC_VIRT_BASIC) |-> sync_wr_o.restart_an)
        else $error("basic control write without restart");

    // busy, ready and overflow flags
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            loader_busy_o <= 1'b0;
            ready_o <= 1'b0;
            addr_overflow_o <= 1'b0;
        end else begin
            loader_busy_o <= state != eeprom_loader_pkg::S_IDLE || start_pend;
            ready_o <= state == eeprom_loader_pkg::S_IDLE && !start_pend;
            if (state == eeprom_loader_pkg::S_IDLE && start_pend) begin
                addr_overflow_o <= 1'b0;
            end else if (state == eeprom_loader_pkg::S_RD_REQ && over_limit) begin
                addr_overflow_o <= 1'b1;
            end
        end
    end

    a_busy_ready: assert property ($past(rst_n_i) |-> loader_busy_o != ready_o)
        else $error("ready not inverse of busy");
    a_start_busy: assert property (state == eeprom_loader_pkg::S_IDLE && start_pend
        |=> ##1 loader_busy_o && !ready_o) else $error("start did not raise busy");
    a_ovf_stop: assert property (state == eeprom_loader_pkg::S_RD_REQ && over_limit
        |=> addr_overflow_o ##1 !loader_busy_o) else $error("overflow not flagged and stopped");

    // register read port, data valid the cycle after the strobe only
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bus_rdata_o <= 32'h0000_0000;
        end else begin
            bus_rdata_o <= 32'h0000_0000;
            if (bus_rd_i) begin
                case (bus_addr_i)
                    eeprom_loader_pkg::REG_CMD: begin
                        bus_rdata_o[eeprom_loader_pkg::CMD_BUSY_BIT] <= loader_busy_o;
                        bus_rdata_o[eeprom_loader_pkg::CMD_OVERFLOW_BIT] <= addr_overflow_o;
                    end
                    eeprom_loader_pkg::REG_HARDWARE_CONFIG_REG: begin
                        bus_rdata_o[eeprom_loader_pkg::HW_READY_BIT] <= ready_o;
                    end
                    eeprom_loader_pkg::REG_MAC_LOW: bus_rdata_o <= mac_addr_low_o;
                    eeprom_loader_pkg::REG_MAC_HIGH: bus_rdata_o <= {16'h0000, mac_addr_high_o};
                    eeprom_loader_pkg::REG_STRAP: bus_rdata_o <= strap_o;
                    default: bus_rdata_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule : eeprom_config_loader

/* File: eeprom_config_loader_tb_top.sv */
`timescale 1ns/1ps
module eeprom_config_loader_tb_top;
    logic mclk_i = 0, rst_n_i = 0, bus_wr_i = 0, bus_rd_i = 0, csr_i = 0, pmi_i = 0;
    logic [7:0] bus_addr_i = 8'h00, ee_data;
    logic [31:0] bus_wdata_i = 32'h0, pins = 32'h0, rdata, mlo, strap, e_mlo, e_strap, d;
    logic [1:0] size = 2'h2, bh = 2'h0;
    eeprom_loader_pkg::ee_read_t ee_rd;
    eeprom_loader_pkg::reg_write_t reg_wr;
    eeprom_loader_pkg::sync_write_t sync_wr;
    logic [15:0] mhi, e_mhi;
    logic busy, rdy, ovf, ee_done, slow = 0;
    int fails = 0, cmp_count = 0, seed = 32'h81a3a643, cyc = 0, nrd, nsync, e_rd, e_ovf;
    logic [41:0] got_q[$], exp_q[$];

    eeprom_config_loader u_eeprom_config_loader (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i), .bus_wr_i(bus_wr_i),
        .bus_rd_i(bus_rd_i), .bus_rdata_o(rdata), .strap_pins_i(pins),
        .eeprom_size_strap_i(size), .ee_rd_o(ee_rd), .ee_done_i(ee_done),
        .ee_data_i(ee_data), .csr_busy_i(csr_i), .pmi_busy_i(pmi_i), .reg_wr_o(reg_wr),
        .sync_wr_o(sync_wr), .mac_addr_low_o(mlo), .mac_addr_high_o(mhi), .strap_o(strap),
        .loader_busy_o(busy), .ready_o(rdy), .addr_overflow_o(ovf));
    ee_model u_ee_model (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .rd_i(ee_rd), .slow_i(slow),
        .done_o(ee_done), .data_o(ee_data));

    initial forever #25 mclk_i = ~mclk_i;

    task chk(input logic [41:0] g, input logic [41:0] e, input string m);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask : chk

    task wrap_up;
        $display("checks %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    always @(posedge mclk_i) begin
        csr_i <= ($random(seed) & 3) == 0;
        pmi_i <= ($random(seed) & 7) == 0;
        bh <= {bh[0], csr_i | pmi_i};
        cyc++;
        if (reg_wr.wr) got_q.push_back({reg_wr.addr, reg_wr.data});
        if (reg_wr.wr | sync_wr.wr) chk(bh[1], 0, "write while busy");
        if (sync_wr.wr) begin
            chk(sync_wr.sel, nsync, "resync order");
            chk(sync_wr.restart_an, sync_wr.sel inside {2, 5, 8}, "restart");
            nsync++;
        end
        if (ee_rd.req) chk(ee_rd.addr, nrd, "read address");
        if (ee_rd.req) nrd++;
        if (busy) chk(rdy, 0, "ready while busy");
        if (cyc == 30000) begin
            fails++;
            wrap_up();
        end
    end

    function logic [7:0] eb(input int i);
        return u_ee_model.mem[i];
    endfunction : eb

    task fill(input logic [7:0] f0, f7, f12, input int nb);
        int a;
        int c;
        for (int i = 0; i < 2048; i++) u_ee_model.mem[i] = 8'($random(seed));
        u_ee_model.mem[0] = f0;
        u_ee_model.mem[7] = f7;
        u_ee_model.mem[12] = f12;
        u_ee_model.mem[13] = nb[7:0];
        a = 14;
        // counts cycle 0, 1, 2: empty burst included
        for (int b = 0; b < nb; b++) begin
            c = b % 3;
            u_ee_model.mem[a] = 8'($random(seed)) & 8'h3f;
            u_ee_model.mem[a + 1] = c[7:0];
            a += 2 + 4 * c;
        end
    endtask : fill

    task wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_i);
        bus_addr_i <= a;
        bus_wdata_i <= v;
        bus_wr_i <= 1'b1;
        @(posedge mclk_i);
        bus_wr_i <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge mclk_i);
        bus_addr_i <= a;
        bus_rd_i <= 1'b1;
        @(posedge mclk_i);
        bus_rd_i <= 1'b0;
        @(negedge mclk_i);
        d = rdata;
    endtask : rd

    task clr;
        nrd = 0;
        nsync = 0;
        got_q.delete();
    endtask : clr

    task rst(input logic [1:0] sz);
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        size <= sz;
        pins <= $random(seed);
        repeat (10) @(posedge mclk_i);
        clr();
        e_strap = pins;
        rst_n_i <= 1'b1;
    endtask : rst

    task fin(input int lim);
        int a;
        int c;
        logic [7:0] s;
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(busy, 1, "busy on start");
        // host stays off the bus until loading ends
        while (busy !== 1'b0) @(posedge mclk_i);
        exp_q.delete();
        e_ovf = 0;
        e_rd = 1;
        if (eb(0) === 8'ha5) begin
            e_mlo = {eb(4), eb(3), eb(2), eb(1)};
            e_mhi = {eb(6), eb(5)};
            if (eb(7) === 8'ha5) e_strap = {eb(11), eb(10), eb(9), eb(8)};
            e_rd = 13;
            if (eb(12) === 8'ha5) begin
                a = 14;
                for (int b = 0; b < eb(13) && !e_ovf; b++) begin
                    if (a + 1 > lim) e_ovf = 1;
                    s = eb(a);
                    c = eb(a + 1);
                    a += 2;
                    for (int k = 0; k < c && !e_ovf; k++) begin
                        if (a + 3 > lim) e_ovf = 1;
                        else exp_q.push_back({8'(s + k), 2'b00, eb(a), eb(a + 1), eb(a + 2), eb(a + 3)});
                        a += 4;
                    end
                end
                e_rd = e_ovf ? lim + 1 : a;
            end
        end
        chk(nrd, e_rd, "read count");
        chk(nsync, 13, "resync count");
        chk(got_q.size(), exp_q.size(), "burst write count");
        foreach (exp_q[i]) chk(got_q[i], exp_q[i], "burst write");
        rd(8'h0c);
        chk(d, e_mlo, "mac low");
        rd(8'h10);
        chk(d, {16'h0, e_mhi}, "mac high");
        rd(8'h14);
        chk(d, e_strap, "straps");
        rd(8'h00);
        chk({d[31], d[9]}, {1'b0, e_ovf[0]}, "command status");
        rd(8'h04);
        chk(d[27], 1, "ready");
        chk(mlo, e_mlo, "mac low output");
        chk(mhi, e_mhi, "mac high output");
        chk(strap, e_strap, "strap output");
        chk({ovf, rdy}, {e_ovf[0], 1'b1}, "flag outputs");
        $display("test end at %0t", $time);
    endtask : fin

    initial begin
        e_mlo = 0;
        e_mhi = 0;
        fill(8'ha5, 8'ha5, 8'ha5, 3);
        rst(2'h2);
        fin(2047);
        fill(8'h5a, 8'ha5, 8'ha5, 3);
        slow = 1;
        clr();
        wr(8'h00, 32'h1);
        fin(2047);
        fill(8'ha5, 8'h00, 8'h3c, 3);
        slow = 0;
        clr();
        wr(8'h08, 32'h1);
        fin(2047);
        fill(8'ha5, 8'h11, 8'ha5, 200);
        rst(2'h0);
        fin(127);
        fill(8'ha5, 8'ha5, 8'ha5, 200);
        rst(2'h1);
        fin(511);
        rd(8'h20);
        chk(d, 0, "unmapped read");
        wrap_up();
    end
endmodule : eeprom_config_loader_tb_top

/* File: eeprom_loader_pkg.sv */
package eeprom_loader_pkg;

    // eeprom image layout, byte addresses
    localparam int EE_AW = 12;
    localparam logic [7:0] VALID_FLAG = 8'ha5;
    localparam logic [11:0] ADDR_VALID = 12'h000;
    localparam logic [11:0] ADDR_MAC_LO_3 = 12'h004;
    localparam logic [11:0] ADDR_MAC_HI_1 = 12'h006;
    localparam logic [11:0] ADDR_STRAP_FLAG = 12'h007;
    localparam logic [11:0] ADDR_STRAP_FIRST = 12'h008;
    localparam logic [11:0] ADDR_STRAP_LAST = 12'h00b;
    localparam logic [11:0] ADDR_BURST_FLAG = 12'h00c;
    localparam logic [11:0] ADDR_BURST_COUNT = 12'h00d;

    // top address per size strap range
    localparam logic [1:0] SIZE_7BIT = 2'h0;
    localparam logic [1:0] SIZE_9BIT = 2'h1;
    localparam logic [11:0] LIMIT_7BIT = 12'h07f;
    localparam logic [11:0] LIMIT_9BIT = 12'h1ff;
    localparam logic [11:0] LIMIT_11BIT = 12'h7ff;

    // burst byte positions: header start, header count, then 4 data bytes
    localparam logic [2:0] POS_HDR_ADDR = 3'h0;
    localparam logic [2:0] POS_HDR_COUNT = 3'h1;
    localparam logic [2:0] POS_DATA_FIRST = 3'h2;
    localparam logic [2:0] POS_DATA_LAST = 3'h5;

    // register port map
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_HARDWARE_CONFIG_REG = 8'h04;
    localparam logic [7:0] REG_RESET_CONTROL_REG = 8'h08;
    localparam logic [7:0] REG_MAC_LOW = 8'h0c;
    localparam logic [7:0] REG_MAC_HIGH = 8'h10;
    localparam logic [7:0] REG_STRAP = 8'h14;
    localparam int CMD_BUSY_BIT = 31;
    localparam int CMD_OVERFLOW_BIT = 9;
    localparam int CMD_RELOAD_BIT = 0;
    localparam int HW_READY_BIT = 27;
    localparam int RESET_DIGITAL_BIT = 0;

    // strap-driven register resync order
    localparam logic [3:0] SYNC_PORT1_BASIC = 4'h2;
    localparam logic [3:0] SYNC_PORT2_BASIC = 4'h5;
    localparam logic [3:0] SYNC_VIRT_BASIC = 4'h8;
    localparam logic [3:0] SYNC_LAST = 4'hc;

    typedef struct packed {
        logic req;
        logic [11:0] addr;
    } ee_read_t;

    typedef struct packed {
        logic wr;
        logic [9:0] addr;
        logic [31:0] data;
    } reg_write_t;

    typedef struct packed {
        logic wr;
        logic [3:0] sel;
        logic restart_an;
    } sync_write_t;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_RD_REQ = 7'h02,
        S_RD_WAIT = 7'h04,
        S_DISPATCH = 7'h08,
        S_WAIT_FREE = 7'h10,
        S_SYNC_WR = 7'h20,
        S_BURST_WR = 7'h40
    } loader_state_t;

endpackage : eeprom_loader_pkg
